// File: include/ppol_pkg.sv
// Package with register map, field layout and reset values for the port pin override block.
package ppol_pkg;
  localparam int PPOL_PINS = 8;
  localparam logic [3:0] PPOL_ADDR_LATCH  = 4'h0;
  localparam logic [3:0] PPOL_ADDR_DIR    = 4'h1;
  localparam logic [3:0] PPOL_ADDR_PIN    = 4'h2;
  localparam logic [3:0] PPOL_ADDR_CTRL   = 4'h3;
  localparam logic [3:0] PPOL_ADDR_IRQEN  = 4'h4;
  localparam logic [3:0] PPOL_ADDR_SENSE  = 4'h5;
  localparam logic [3:0] PPOL_ADDR_STATUS = 4'h6;
  localparam logic [3:0] PPOL_ADDR_MASK   = 4'h7;
  localparam int PPOL_CTRL_PUD_BIT   = 0;
  localparam int PPOL_CTRL_SLEEP_BIT = 1;
  localparam logic [7:0] PPOL_RST_BYTE = 8'h00;
  localparam logic [31:0] PPOL_UNMAPPED_DATA = 32'h00000000;
  localparam int PPOL_SYNC_STAGES = 3;
endpackage

// File: include/ppol_ovr_if.sv
// Interface carrying per-pin pad controls from the main module to the pad stage.
`timescale 1ns/1ps
`default_nettype none
interface ppol_ovr_if #(parameter int N = 8);
  logic [N-1:0] pu_en;
  logic [N-1:0] drv_en;
  logic [N-1:0] drv_val;
  logic [N-1:0] in_en;
  logic [N-1:0] pad_in;
  logic [N-1:0] di;
  modport ctrl (output pu_en, output drv_en, output drv_val, output in_en, input di);
  modport pad  (input pu_en, input drv_en, input drv_val, input in_en, input pad_in,
                output di);
endinterface
`default_nettype wire

// File: verilog/ppol_pad_stage.sv
// Pad stage: input clamp and the tap that feeds alternate-function inputs.
`timescale 1ns/1ps
`default_nettype none
module ppol_pad_stage
  import ppol_pkg::*;
(
  ppol_ovr_if.pad bus
);
  // The clamp sits before the schmitt trigger, so a floating pad draws no current.
  always_comb begin
    bus.di = bus.pad_in & bus.in_en;
  end
endmodule
`default_nettype wire

// File: verilog/ppol_port.sv
// Port pin override logic with Avalon-MM register access and pin interrupts.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Sleep clamp forces digital input low.
// - Enabled external interrupt pins escape clamp.
// - Clamp release on high pin sets flag.
// - Reset disables every pull-up.
// - Pull-up from override, else 0b010 decode, blocked while driver enabled.
// - Driver enable from override, else direction.
// - Driven value from override, else latch.
// - Input enable override beats sleep state.
// - Alternate input tapped before synchronizer.
// - Clock, clamp, pull-up disable shared.
// - Direction one output, zero input.
module ppol_port
  import ppol_pkg::*;
#(
  parameter int N = PPOL_PINS
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [3:0]   i_avs_address,
  input  wire logic         i_avs_read,
  input  wire logic         i_avs_write,
  input  wire logic [31:0]  i_avs_writedata,
  input  wire logic [3:0]   i_avs_byteenable,
  output logic [31:0]       o_avs_readdata,
  output logic              o_avs_waitrequest,
  input  wire logic [N-1:0] i_pullup_override_en,
  input  wire logic [N-1:0] i_pullup_override_val,
  input  wire logic [N-1:0] i_dir_override_en,
  input  wire logic [N-1:0] i_dir_override_val,
  input  wire logic [N-1:0] i_value_override_en,
  input  wire logic [N-1:0] i_value_override_val,
  input  wire logic [N-1:0] i_input_en_override_en,
  input  wire logic [N-1:0] i_input_en_override_val,
  input  wire logic [N-1:0] i_pad_in,
  output logic [N-1:0]      o_pad_out,
  output logic [N-1:0]      o_pad_oe,
  output logic [N-1:0]      o_pad_pullup,
  output logic [N-1:0]      o_alt_digital_in,
  output logic              o_irq
);
  ppol_ovr_if #(.N(N)) ovr ();

  logic [N-1:0] pin_output_latch_reg;
  logic [N-1:0] pin_direction_bit_reg;
  logic [N-1:0] pin_input_sample_reg;
  logic         global_pullup_disable_reg;
  logic         sleep_clamp_reg;
  logic [N-1:0] irq_en_reg;
  logic [N-1:0] sense_edge_reg;
  logic [N-1:0] status_reg;
  logic [N-1:0] mask_reg;
  logic [N-1:0] ovr_pu_en_reg;
  logic [N-1:0] ovr_pu_val_reg;
  logic [N-1:0] ovr_dir_en_reg;
  logic [N-1:0] ovr_dir_val_reg;
  logic [N-1:0] ovr_pv_en_reg;
  logic [N-1:0] ovr_pv_val_reg;
  logic [N-1:0] ovr_ie_en_reg;
  logic [N-1:0] ovr_ie_val_reg;
  logic [N-1:0] sync1_reg;
  logic [N-1:0] sync2_reg;
  logic [N-1:0] sync3_reg;
  logic [N-1:0] pin_prev_reg;
  logic         ack_reg;
  logic [31:0]  readdata_reg;
  logic [N-1:0] edge_evt;
  logic         wr_strobe;
  logic         rd_strobe;

  // Byte lane zero carries every register, so only that lane enables a write.
  function automatic logic [N-1:0] wr_byte(input logic [N-1:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    wr_byte = be[0] ? wd[N-1:0] : old_v;
  endfunction

  // Answer on the second edge so read data come from a register.
  assign wr_strobe = i_avs_write & ~ack_reg;
  assign rd_strobe = i_avs_read & ~ack_reg;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_output_latch_reg      <= PPOL_RST_BYTE[N-1:0];
      pin_direction_bit_reg     <= PPOL_RST_BYTE[N-1:0];
      global_pullup_disable_reg <= 1'b0;
      sleep_clamp_reg           <= 1'b0;
      irq_en_reg                <= PPOL_RST_BYTE[N-1:0];
      sense_edge_reg            <= PPOL_RST_BYTE[N-1:0];
      mask_reg                  <= PPOL_RST_BYTE[N-1:0];
    end else if (wr_strobe) begin
      case (i_avs_address)
        PPOL_ADDR_LATCH: begin
          pin_output_latch_reg <= wr_byte(pin_output_latch_reg, i_avs_writedata,
                                          i_avs_byteenable);
        end
        PPOL_ADDR_DIR: begin
          pin_direction_bit_reg <= wr_byte(pin_direction_bit_reg, i_avs_writedata,
                                           i_avs_byteenable);
        end
        PPOL_ADDR_CTRL: begin
          if (i_avs_byteenable[0]) begin
            global_pullup_disable_reg <= i_avs_writedata[PPOL_CTRL_PUD_BIT];
            sleep_clamp_reg           <= i_avs_writedata[PPOL_CTRL_SLEEP_BIT];
          end
        end
        PPOL_ADDR_IRQEN: begin
          irq_en_reg <= wr_byte(irq_en_reg, i_avs_writedata, i_avs_byteenable);
        end
        PPOL_ADDR_SENSE: begin
          sense_edge_reg <= wr_byte(sense_edge_reg, i_avs_writedata, i_avs_byteenable);
        end
        PPOL_ADDR_MASK: begin
          mask_reg <= wr_byte(mask_reg, i_avs_writedata, i_avs_byteenable);
        end
        default: begin
        end
      endcase
    end
  end

  // Override inputs are registered so every pad output comes from a flip-flop.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovr_pu_en_reg  <= PPOL_RST_BYTE[N-1:0];
      ovr_pu_val_reg <= PPOL_RST_BYTE[N-1:0];
      ovr_dir_en_reg <= PPOL_RST_BYTE[N-1:0];
      ovr_dir_val_reg <= PPOL_RST_BYTE[N-1:0];
      ovr_pv_en_reg  <= PPOL_RST_BYTE[N-1:0];
      ovr_pv_val_reg <= PPOL_RST_BYTE[N-1:0];
      ovr_ie_en_reg  <= PPOL_RST_BYTE[N-1:0];
      ovr_ie_val_reg <= PPOL_RST_BYTE[N-1:0];
    end else begin
      ovr_pu_en_reg   <= i_pullup_override_en;
      ovr_pu_val_reg  <= i_pullup_override_val;
      ovr_dir_en_reg  <= i_dir_override_en;
      ovr_dir_val_reg <= i_dir_override_val;
      ovr_pv_en_reg   <= i_value_override_en;
      ovr_pv_val_reg  <= i_value_override_val;
      ovr_ie_en_reg   <= i_input_en_override_en;
      ovr_ie_val_reg  <= i_input_en_override_val;
    end
  end

  always_comb begin
    for (int k = 0; k < N; k++) begin
      ovr.pu_en[k] = ovr_pu_en_reg[k] ? ovr_pu_val_reg[k]
                   : ({pin_direction_bit_reg[k], pin_output_latch_reg[k],
                       global_pullup_disable_reg} == 3'b010);
      ovr.drv_en[k] = ovr_dir_en_reg[k] ? ovr_dir_val_reg[k]
                    : pin_direction_bit_reg[k];
      ovr.drv_val[k] = ovr_pv_en_reg[k] ? ovr_pv_val_reg[k]
                     : pin_output_latch_reg[k];
      ovr.in_en[k] = ovr_ie_en_reg[k] ? ovr_ie_val_reg[k]
                   : (~sleep_clamp_reg | irq_en_reg[k]);
    end
  end
  assign ovr.pad_in = i_pad_in;

  ppol_pad_stage u_pad (
    .bus (ovr.pad)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pad_pullup <= PPOL_RST_BYTE[N-1:0];
      o_pad_oe     <= PPOL_RST_BYTE[N-1:0];
      o_pad_out    <= PPOL_RST_BYTE[N-1:0];
    end else begin
      o_pad_pullup <= ovr.pu_en & ~ovr.drv_en;
      o_pad_oe     <= ovr.drv_en;
      o_pad_out    <= ovr.drv_en & ovr.drv_val;
    end
  end

  // One register stage on the tap; receivers add their own synchroniser.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_alt_digital_in <= PPOL_RST_BYTE[N-1:0];
    end else begin
      o_alt_digital_in <= ovr.di;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg            <= PPOL_RST_BYTE[N-1:0];
      sync2_reg            <= PPOL_RST_BYTE[N-1:0];
      sync3_reg            <= PPOL_RST_BYTE[N-1:0];
      pin_input_sample_reg <= PPOL_RST_BYTE[N-1:0];
      pin_prev_reg         <= PPOL_RST_BYTE[N-1:0];
    end else begin
      sync1_reg <= ovr.di;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int k = 0; k < N; k++) begin
        if (sync2_reg[k] == sync3_reg[k]) begin
          pin_input_sample_reg[k] <= sync3_reg[k];
        end
      end
      pin_prev_reg <= pin_input_sample_reg;
    end
  end

  // Sense any change even on disabled pins, so clamp release on a high pin flags.
  always_comb begin
    edge_evt = (pin_input_sample_reg ^ pin_prev_reg) & sense_edge_reg;
  end

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_reg <= PPOL_RST_BYTE[N-1:0];
    end else if (wr_strobe && i_avs_address == PPOL_ADDR_STATUS && i_avs_byteenable[0]) begin
      status_reg <= (status_reg & ~i_avs_writedata[N-1:0]) | edge_evt;
    end else begin
      status_reg <= status_reg | edge_evt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status_reg & mask_reg);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      readdata_reg <= PPOL_UNMAPPED_DATA;
    end else if (rd_strobe) begin
      case (i_avs_address)
        PPOL_ADDR_LATCH:  readdata_reg <= 32'(pin_output_latch_reg);
        PPOL_ADDR_DIR:    readdata_reg <= 32'(pin_direction_bit_reg);
        PPOL_ADDR_PIN:    readdata_reg <= 32'(pin_input_sample_reg);
        PPOL_ADDR_CTRL:   readdata_reg <= {30'h00000000, sleep_clamp_reg,
                                           global_pullup_disable_reg};
        PPOL_ADDR_IRQEN:  readdata_reg <= 32'(irq_en_reg);
        PPOL_ADDR_SENSE:  readdata_reg <= 32'(sense_edge_reg);
        PPOL_ADDR_STATUS: readdata_reg <= 32'(status_reg);
        PPOL_ADDR_MASK:   readdata_reg <= 32'(mask_reg);
        default:          readdata_reg <= PPOL_UNMAPPED_DATA;
      endcase
    end
  end

  assign o_avs_readdata = readdata_reg;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_reg);
    end
  end
endmodule
`default_nettype wire

// File: bench/ppol_port_sva.sv
// Checker of the port pin override block, watching its top-level ports.
`timescale 1ns/1ps
`default_nettype none
module ppol_port_sva #(
  parameter int N = 8
) (
  input wire logic         i_clk,
  input wire logic         i_rst_b,
  input wire logic         i_avs_read,
  input wire logic         i_avs_write,
  input wire logic [31:0]  o_avs_readdata,
  input wire logic         o_avs_waitrequest,
  input wire logic [N-1:0] i_pullup_override_en,
  input wire logic [N-1:0] i_pullup_override_val,
  input wire logic [N-1:0] i_dir_override_en,
  input wire logic [N-1:0] i_dir_override_val,
  input wire logic [N-1:0] i_value_override_en,
  input wire logic [N-1:0] i_value_override_val,
  input wire logic [N-1:0] i_input_en_override_en,
  input wire logic [N-1:0] i_input_en_override_val,
  input wire logic [N-1:0] o_pad_out,
  input wire logic [N-1:0] o_pad_oe,
  input wire logic [N-1:0] o_pad_pullup,
  input wire logic [N-1:0] o_alt_digital_in
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_done;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  a_wait_answer: assert property (s_req |=> s_done)
    else $error("bus answer late or held");
  a_upper_zero: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:N] == '0)
    else $error("upper read bits not zero");
  a_pull_reset: assert property ($rose(i_rst_b) |-> o_pad_pullup == '0)
    else $error("pull-up on out of reset");
  a_no_pull_drive: assert property ((o_pad_pullup & o_pad_oe) == '0)
    else $error("pull-up on while driving");
  a_pull_override: assert property (
    ((o_pad_pullup ^ ($past(i_pullup_override_val, 2) & ~o_pad_oe))
    & $past(i_pullup_override_en, 2)) == '0)
    else $error("pull-up ignores override");
  a_oe_override: assert property (
    ((o_pad_oe ^ $past(i_dir_override_val, 2)) & $past(i_dir_override_en, 2)) == '0)
    else $error("driver enable ignores override");
  a_val_override: assert property (
    ((o_pad_out ^ $past(i_value_override_val, 2))
    & $past(i_value_override_en, 2) & o_pad_oe) == '0)
    else $error("driven value ignores override");
  a_input_off: assert property (
    ($past(i_input_en_override_en, 2)
    & ~$past(i_input_en_override_val, 2) & o_alt_digital_in) == '0)
    else $error("disabled input not low");
endmodule
bind ppol_port ppol_port_sva #(.N(N)) u_sva (.*);
`default_nettype wire

// File: bench/ppol_pad_model.sv
// Pad and external line model seen by the port pin override block.
`timescale 1ns/1ps
`default_nettype none
module ppol_pad_model #(
  parameter int N = 8
) (
  input  wire logic         i_clk,
  input  wire logic [N-1:0] i_oe,
  input  wire logic [N-1:0] i_out,
  input  wire logic [N-1:0] i_pullup,
  input  wire logic [N-1:0] i_ext_en,
  input  wire logic [N-1:0] i_ext_val,
  output logic [N-1:0]      o_level
);
  logic [N-1:0] float_reg;
  // A floating line toggles every cycle so a settled unknown never poses as a level.
  always_ff @(posedge i_clk) begin
    float_reg <= (float_reg === '0) ? '1 : '0;
  end
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
    | (~i_oe & ~i_ext_en & (i_pullup | float_reg));
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench of the port pin override block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk, i_rst_b, i_avs_read, i_avs_write, o_avs_waitrequest, o_irq;
  logic [3:0]  i_avs_address, i_avs_byteenable;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [7:0]  i_pullup_override_en, i_pullup_override_val, i_dir_override_en;
  logic [7:0]  i_dir_override_val, i_value_override_en, i_value_override_val;
  logic [7:0]  i_input_en_override_en, i_input_en_override_val, i_pad_in, o_pad_out;
  logic [7:0]  o_pad_oe, o_pad_pullup, o_alt_digital_in, ext_en, ext_val, q;
  int          fail_count, total_checks, cycles;
  ppol_port #(.N(8)) dut (.*);
  ppol_pad_model #(.N(8)) u_pad (.i_clk(i_clk), .i_oe(o_pad_oe), .i_out(o_pad_out),
    .i_pullup(o_pad_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pad_in));
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // The request stands until waitrequest is sampled low; the next call idles one cycle.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= {24'h000000, d};
    i_avs_read <= !wr;
    i_avs_write <= wr;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'h0);
    q = o_avs_readdata[7:0];
    i_avs_read <= 1'h0;
    i_avs_write <= 1'h0;
  endtask
  task automatic settle;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic t_regs;
    chk("wait in idle", 8'h01, {7'h00, o_avs_waitrequest});
    bus(1'h1, 4'h0, 8'h0F);
    bus(1'h1, 4'h1, 8'h03);
    settle;
    chk("oe", 8'h03, o_pad_oe);
    chk("out", 8'h03, o_pad_out);
    chk("pullup", 8'h0C, o_pad_pullup);
    bus(1'h1, 4'h3, 8'h01);
    settle;
    chk("pullup pud", 8'h00, o_pad_pullup);
    bus(1'h1, 4'h3, 8'h00);
    settle;
    i_rst_b <= 1'h0;
    settle;
    chk("pullup in reset", 8'h00, o_pad_pullup);
    i_rst_b <= 1'h1;
    settle;
    chk("oe after reset", 8'h00, o_pad_oe);
  endtask
  task automatic t_ovr;
    bus(1'h1, 4'h0, 8'hC0);
    i_dir_override_en <= 8'hFF;
    i_dir_override_val <= 8'hF0;
    i_value_override_en <= 8'h30;
    i_value_override_val <= 8'h10;
    i_pullup_override_en <= 8'h0F;
    i_pullup_override_val <= 8'h05;
    settle;
    chk("oe ovr", 8'hF0, o_pad_oe);
    chk("out ovr", 8'hD0, o_pad_out);
    chk("pullup ovr", 8'h05, o_pad_pullup);
    i_dir_override_en <= 8'h00;
    i_value_override_en <= 8'h00;
    i_pullup_override_en <= 8'h00;
    settle;
    chk("pullup latch", 8'hC0, o_pad_pullup);
  endtask
  task automatic t_sleep;
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    bus(1'h1, 4'h0, 8'h00);
    bus(1'h1, 4'h4, 8'h01);
    bus(1'h1, 4'h3, 8'h02);
    settle;
    chk("alt clamped", 8'h01, o_alt_digital_in);
    i_input_en_override_en <= 8'h03;
    i_input_en_override_val <= 8'h02;
    settle;
    chk("alt ie ovr", 8'h02, o_alt_digital_in);
    bus(1'h0, 4'h2, 8'h00);
    chk("pin sample", 8'h02, q);
    i_input_en_override_en <= 8'h00;
  endtask
  task automatic t_wake;
    bus(1'h1, 4'h5, 8'h04);
    bus(1'h1, 4'h7, 8'h04);
    settle;
    bus(1'h1, 4'h6, 8'hFF);
    settle;
    chk("irq asleep", 8'h00, {7'h00, o_irq});
    bus(1'h1, 4'h3, 8'h00);
    settle;
    chk("irq wake", 8'h01, {7'h00, o_irq});
    chk("alt awake", 8'hFF, o_alt_digital_in);
    bus(1'h0, 4'h6, 8'h00);
    chk("status", 8'h04, q);
    bus(1'h1, 4'h7, 8'h00);
    settle;
    chk("irq masked", 8'h00, {7'h00, o_irq});
    bus(1'h1, 4'h7, 8'h04);
    bus(1'h1, 4'h6, 8'h04);
    settle;
    chk("irq cleared", 8'h00, {7'h00, o_irq});
    bus(1'h1, 4'hA, 8'h55);
    bus(1'h0, 4'hA, 8'h00);
    chk("unmapped", 8'h00, q);
  endtask
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out;
    end
  end
  initial begin
    {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata, i_rst_b} = '0;
    {i_pullup_override_en, i_pullup_override_val, i_dir_override_en} = '0;
    {i_dir_override_val, i_value_override_en, i_value_override_val} = '0;
    {i_input_en_override_en, i_input_en_override_val, ext_en, ext_val} = '0;
    i_avs_byteenable = 4'hF;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'h1;
    t_regs;
    t_ovr;
    t_sleep;
    t_wake;
    close_out;
  end
endmodule
`default_nettype wire
